//--- pump_pressure_supervisor.sv
// pump pressure supervisor: sleep/wake, limits, loss detection, probing
// assumes feedback and frequency come from other clock domains
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pump_pressure_supervisor #(
   // clocks per 0.1 s supervision tick; benches may shorten it
   parameter int unsigned TICK_LEN = pump_supervisor_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire  logic        clk_i,
   input  wire  logic        rst_n_i,
   // avalon-mm slave
   input  wire  logic [5:0]  address_i,
   input  wire  logic        read_i,
   input  wire  logic        write_i,
   input  wire  logic [31:0] writedata_i,
   output var   logic [31:0] readdata_o,
   output var   logic        waitrequest_o,
   // process side
   input  wire  logic [15:0] feedback_i,
   input  wire  logic [15:0] out_freq_i,
   output var   logic        freq_down_o,
   output var   logic        freq_up_o,
   output var   logic        normal_decel_o,
   output var   logic        sleep_o,
   output var   logic        probe_active_o,
   output var   logic        probe_down_o,
   output var   logic        high_pressure_warning_o,
   output var   logic        high_pressure_stop_error_o,
   output var   logic        low_pressure_warning_o,
   output var   logic        low_pressure_stop_error_o,
   output var   logic        feedback_loss_fault_o,
   output var   logic        loss_warning_o,
   output var   logic        drive_stop_o
);
   import pump_supervisor_pkg::*;

   // ==========================================================
   // helpers
   // percent (0..100, or 0..1000 tenths) of a base, in psi units
   function automatic logic [15:0] pct(input logic [15:0] base,
                                       input logic [15:0] p,
                                       input logic [15:0] div);
      logic [31:0] prod;
      prod = base * p;
      pct = 16'(prod / {16'h0, div});
   endfunction

   // ==========================================================
   // input synchronisers, two flops each
   logic [15:0] fb_m_q, fb_q, fq_m_q, fq_q;  // meta and stable stages
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fb_m_q <= 16'h0;
         fb_q   <= 16'h0;
         fq_m_q <= 16'h0;
         fq_q   <= 16'h0;
      end else begin
         fb_m_q <= feedback_i;
         fb_q   <= fb_m_q;
         fq_m_q <= out_freq_i;
         fq_q   <= fq_m_q;
      end
   end

   // ==========================================================
   // settings registers
   logic [15:0] setpoint_q, fullscale_q, tol_q, maxlim_q, minlim_q;
   logic [15:0] sleepfrq_q, sleeptim_q;      // 0.01 hz, 0.1 s
   logic [15:0] hi_warn_t_q, hi_stop_t_q;    // 0.1 s
   logic [15:0] lo_warn_t_q, lo_stop_t_q;    // 0.1 s
   logic [15:0] loss_t_q, loss_pct_q;        // 0.1 s, 0.1 %
   logic [1:0]  hi_mode_q, lo_mode_q, loss_sel_q;
   logic        unit_pct_q;                  // 1 = percent units
   logic [15:0] prb_band_q, prb_period_q;
   logic        prb_dir_q;
   logic [15:0] acc2_q, dec2_q;              // shared with probe ramps
   logic [31:0] pid_q;                       // gains, live writable

   // bus decode
   wire wr_en = write_i && !waitrequest_o;   // stored at answering edge
   wire [15:0] wlo = writedata_i[15:0];
   wire [15:0] whi = writedata_i[31:16];

   // settings write process
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         setpoint_q  <= SETPOINT_RST;
         fullscale_q <= FULLSCALE_RST;
         tol_q       <= 16'h0;
         maxlim_q    <= 16'hffff;
         minlim_q    <= 16'h0;
         sleepfrq_q  <= 16'h0;
         sleeptim_q  <= 16'h0;
         hi_warn_t_q <= 16'h0;
         hi_stop_t_q <= 16'h0;
         lo_warn_t_q <= 16'h0;
         lo_stop_t_q <= 16'h0;
         loss_t_q    <= 16'h0;
         loss_pct_q  <= 16'h0;
         hi_mode_q   <= MODE_OFF;
         lo_mode_q   <= MODE_OFF;
         loss_sel_q  <= MODE_OFF;
         unit_pct_q  <= 1'b0;
         prb_band_q  <= 16'h0;
         prb_period_q<= 16'h0;
         prb_dir_q   <= 1'b0;
         acc2_q      <= 16'h0001;
         dec2_q      <= 16'h0001;
         pid_q       <= 32'h0;
      end else if (wr_en) begin
         case (address_i)
            OFS_SETPOINT:  setpoint_q  <= wlo;
            OFS_FULLSCALE: fullscale_q <= wlo;
            OFS_TOLERANCE: tol_q       <= wlo;
            OFS_MAXLIM:    maxlim_q    <= wlo;
            OFS_MINLIM:    minlim_q    <= wlo;
            OFS_SLEEPFRQ:  sleepfrq_q  <= wlo;
            OFS_SLEEPTIM:  sleeptim_q  <= wlo;
            OFS_HITIMES: begin
               hi_warn_t_q <= wlo;
               hi_stop_t_q <= whi;
            end
            OFS_LOTIMES: begin
               lo_warn_t_q <= wlo;
               lo_stop_t_q <= whi;
            end
            OFS_LOSS: begin
               loss_t_q    <= wlo;
               loss_pct_q  <= whi;
            end
            OFS_MODES: begin
               hi_mode_q   <= writedata_i[1:0];
               lo_mode_q   <= writedata_i[3:2];
               loss_sel_q  <= writedata_i[5:4];
               unit_pct_q  <= writedata_i[8];
            end
            OFS_PROBE: begin
               prb_band_q   <= wlo;
               prb_period_q <= {1'b0, writedata_i[30:16]};
               prb_dir_q    <= writedata_i[31]; // kept out of the period
            end
            // one storage for probe and second ramp times
            OFS_RAMP2: begin
               acc2_q <= wlo;
               dec2_q <= whi;
            end
            OFS_PID:   pid_q <= writedata_i; // no run interlock
            default: ;                       // unmapped ignored
         endcase
      end
   end

   // ==========================================================
   // effective thresholds in pressure units
   // percent mode: tolerance/band vs setpoint, limits vs fullscale
   wire [15:0] tol_p  = unit_pct_q ? pct(setpoint_q, tol_q, 16'd100)
                                   : tol_q;
   wire [15:0] band_p = unit_pct_q ? pct(setpoint_q, prb_band_q, 16'd100)
                                   : prb_band_q;
   wire [15:0] max_p  = unit_pct_q ? pct(fullscale_q, maxlim_q, 16'd100)
                                   : maxlim_q;
   wire [15:0] min_p  = unit_pct_q ? pct(fullscale_q, minlim_q, 16'd100)
                                   : minlim_q;
   wire [15:0] loss_p = pct(setpoint_q, loss_pct_q, 16'd1000);
   wire [15:0] wake_p = (tol_p > setpoint_q) ? 16'h0 : setpoint_q - tol_p;

   // ==========================================================
   // tick generator
   logic [25:0] tick_cnt_q;
   logic        tick_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_q <= 26'h0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 26'(TICK_LEN - 1)) begin
         tick_cnt_q <= 26'h0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 26'h1;
         tick_q     <= 1'b0;
      end
   end

   // compares sampled on the tick, strict tests
   logic above_sp_q, below_wake_q, above_max_q, below_min_q, below_loss_q;
   logic below_sfrq_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         above_sp_q   <= 1'b0;
         below_wake_q <= 1'b0;
         above_max_q  <= 1'b0;
         below_min_q  <= 1'b0;
         below_loss_q <= 1'b0;
         below_sfrq_q <= 1'b0;
      end else if (tick_q) begin
         above_sp_q   <= fb_q > setpoint_q;
         below_wake_q <= fb_q < wake_p;
         above_max_q  <= fb_q > max_p;
         below_min_q  <= fb_q < min_p;
         below_loss_q <= fb_q < loss_p;
         below_sfrq_q <= fq_q < sleepfrq_q;
      end
   end

   // ==========================================================
   // sleep / wake loop
   loop_state_t st_q;
   logic [15:0] sl_cnt_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q     <= RUN_S;
         sl_cnt_q <= 16'h0;
      end else if (tick_q) begin
         case (st_q)
            RUN_S: begin
               sl_cnt_q <= 16'h0;
               if (below_sfrq_q)
                  st_q <= SLEEPCNT_S;
            end
            SLEEPCNT_S: begin
               if (below_wake_q || !below_sfrq_q) begin
                  st_q <= RUN_S;
               end else if (sl_cnt_q >= sleeptim_q) begin
                  st_q <= DECEL_S;
               end else begin
                  sl_cnt_q <= sl_cnt_q + 16'h1;
               end
            end
            DECEL_S: begin
               if (below_wake_q)
                  st_q <= RUN_S;
               else if (fq_q == 16'h0)
                  st_q <= SLEEP_S;
            end
            SLEEP_S: begin
               if (below_wake_q)
                  st_q <= RUN_S;
            end
            default: st_q <= RUN_S;
         endcase
      end
   end

   // ==========================================================
   // high and low pressure supervision, separate counters in one process
   logic [15:0] hw_cnt_q, hs_cnt_q, lw_cnt_q, ls_cnt_q, loss_cnt_q;
   logic hiw_q, hie_q, low_q, loe_q, lss_q;
   wire hi_on = hi_mode_q != MODE_OFF;
   wire lo_on = lo_mode_q != MODE_OFF;
   wire loss_on = (loss_pct_q != 16'h0) && (loss_sel_q != MODE_OFF);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hw_cnt_q <= 16'h0; hs_cnt_q <= 16'h0;
         lw_cnt_q <= 16'h0; ls_cnt_q <= 16'h0;
         loss_cnt_q <= 16'h0;
         hiw_q <= 1'b0; hie_q <= 1'b0;
         low_q <= 1'b0; loe_q <= 1'b0; lss_q <= 1'b0;
      end else if (tick_q) begin
         // high side: restart count on drop below limit
         if (!hi_on || !above_max_q) begin
            hw_cnt_q <= 16'h0;
            hs_cnt_q <= 16'h0;
            hiw_q    <= 1'b0;
         end else if (!hiw_q) begin
            if (hw_cnt_q >= hi_warn_t_q) hiw_q <= 1'b1;
            else hw_cnt_q <= hw_cnt_q + 16'h1;
         end else if (hi_mode_q == MODE_STOP && !hie_q) begin
            if (hs_cnt_q >= hi_stop_t_q) hie_q <= 1'b1;
            else hs_cnt_q <= hs_cnt_q + 16'h1;
         end
         if (hi_mode_q != MODE_STOP) hie_q <= 1'b0;
         // low side mirrors high side
         if (!lo_on || !below_min_q) begin
            lw_cnt_q <= 16'h0;
            ls_cnt_q <= 16'h0;
            low_q    <= 1'b0;
         end else if (!low_q) begin
            if (lw_cnt_q >= lo_warn_t_q) low_q <= 1'b1;
            else lw_cnt_q <= lw_cnt_q + 16'h1;
         end else if (lo_mode_q == MODE_STOP && !loe_q) begin
            if (ls_cnt_q >= lo_stop_t_q) loe_q <= 1'b1;
            else ls_cnt_q <= ls_cnt_q + 16'h1;
         end
         if (lo_mode_q != MODE_STOP) loe_q <= 1'b0;
         // loss of pressure
         if (!loss_on || !below_loss_q) begin
            loss_cnt_q <= 16'h0;
            lss_q      <= 1'b0;
         end else if (loss_cnt_q >= loss_t_q) begin
            lss_q <= 1'b1;
         end else begin
            loss_cnt_q <= loss_cnt_q + 16'h1;
         end
      end
   end

   // ==========================================================
   // water pressure probing timer
   logic [15:0] prb_cnt_q;
   logic        prb_q;
   wire prb_on = prb_period_q != 16'h0;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prb_cnt_q <= 16'h0;
         prb_q     <= 1'b0;
      end else if (!prb_on || st_q != RUN_S) begin
         prb_cnt_q <= 16'h0;
         prb_q     <= 1'b0;
      end else if (tick_q) begin
         if (prb_cnt_q >= prb_period_q - 16'h1) begin
            prb_cnt_q <= 16'h0;
            prb_q     <= 1'b1;               // one tick probe start
         end else begin
            prb_cnt_q <= prb_cnt_q + 16'h1;
            prb_q     <= 1'b0;
         end
      end
   end

   // ==========================================================
   // outputs, all registered
   wire [7:0] status_w = {prb_q, lss_q && loss_sel_q == MODE_STOP,
                          lss_q && loss_sel_q == MODE_WARN, loe_q, low_q,
                          hie_q, hiw_q, st_q == SLEEP_S};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         freq_down_o                <= 1'b0;
         freq_up_o                  <= 1'b0;
         normal_decel_o             <= 1'b0;
         sleep_o                    <= 1'b0;
         probe_active_o             <= 1'b0;
         probe_down_o               <= 1'b0;
         high_pressure_warning_o    <= 1'b0;
         high_pressure_stop_error_o <= 1'b0;
         low_pressure_warning_o     <= 1'b0;
         low_pressure_stop_error_o  <= 1'b0;
         feedback_loss_fault_o      <= 1'b0;
         loss_warning_o             <= 1'b0;
         drive_stop_o               <= 1'b0;
      end else begin
         freq_down_o    <= above_sp_q && st_q != SLEEP_S;
         freq_up_o      <= below_wake_q;
         normal_decel_o <= st_q == DECEL_S;
         sleep_o        <= st_q == SLEEP_S;
         probe_active_o <= prb_q;
         probe_down_o   <= prb_q && prb_dir_q;
         high_pressure_warning_o    <= status_w[ST_HIW];
         high_pressure_stop_error_o <= status_w[ST_HIE];
         low_pressure_warning_o     <= status_w[ST_LOW];
         low_pressure_stop_error_o  <= status_w[ST_LOE];
         feedback_loss_fault_o      <= status_w[ST_LSE];
         loss_warning_o             <= status_w[ST_LSW];
         drive_stop_o   <= hie_q || loe_q || status_w[ST_LSE];
      end
   end

   // ==========================================================
   // read mux, answered one cycle after request
   logic [31:0] rd_w;
   always_comb begin
      case (address_i)
         OFS_SETPOINT:  rd_w = {16'h0, setpoint_q};
         OFS_FULLSCALE: rd_w = {16'h0, fullscale_q};
         OFS_TOLERANCE: rd_w = {16'h0, tol_q};
         OFS_MAXLIM:    rd_w = {16'h0, maxlim_q};
         OFS_MINLIM:    rd_w = {16'h0, minlim_q};
         OFS_SLEEPFRQ:  rd_w = {16'h0, sleepfrq_q};
         OFS_SLEEPTIM:  rd_w = {16'h0, sleeptim_q};
         OFS_HITIMES:   rd_w = {hi_stop_t_q, hi_warn_t_q};
         OFS_LOTIMES:   rd_w = {lo_stop_t_q, lo_warn_t_q};
         OFS_LOSS:      rd_w = {loss_pct_q, loss_t_q};
         OFS_MODES:     rd_w = {23'h0, unit_pct_q, 2'h0, loss_sel_q,
                                lo_mode_q, hi_mode_q};
         OFS_PROBE:     rd_w = {prb_dir_q, prb_period_q[14:0], prb_band_q};
         OFS_RAMP2:     rd_w = {dec2_q, acc2_q};
         OFS_PID:       rd_w = pid_q;
         OFS_STATUS:    rd_w = {24'h0, status_w};
         default:       rd_w = UNMAPPED_RD;
      endcase
   end

   // waitrequest high except in the answering cycle
   logic ack_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q         <= 1'b0;
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h0;
      end else begin
         ack_q         <= (read_i || write_i) && !ack_q;
         waitrequest_o <= !((read_i || write_i) && !ack_q);
         readdata_o    <= rd_w;
      end
   end
endmodule
`default_nettype wire

//--- pump_supervisor_pkg.sv
// constants shared by the pump pressure supervisor
// assumes a 50 MHz system clock and 0.01 psi / 0.1 s scaled settings
package pump_supervisor_pkg;
   // ==========================================================
   // clock and tick
   localparam int unsigned CLK_HZ        = 50000000;
   localparam int unsigned TICK_MS       = 100;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [5:0] OFS_SETPOINT   = 6'h00;
   localparam logic [5:0] OFS_FULLSCALE  = 6'h04;
   localparam logic [5:0] OFS_TOLERANCE  = 6'h08;
   localparam logic [5:0] OFS_MAXLIM     = 6'h0c;
   localparam logic [5:0] OFS_MINLIM     = 6'h10;
   localparam logic [5:0] OFS_SLEEPFRQ   = 6'h14;
   localparam logic [5:0] OFS_SLEEPTIM   = 6'h18;
   localparam logic [5:0] OFS_HITIMES    = 6'h1c;
   localparam logic [5:0] OFS_LOTIMES    = 6'h20;
   localparam logic [5:0] OFS_LOSS       = 6'h24;
   localparam logic [5:0] OFS_MODES      = 6'h28;
   localparam logic [5:0] OFS_PROBE      = 6'h2c;
   localparam logic [5:0] OFS_RAMP2      = 6'h30;
   localparam logic [5:0] OFS_PID        = 6'h34;
   localparam logic [5:0] OFS_STATUS     = 6'h38;
   // ==========================================================
   // reset values and modes
   localparam logic [15:0] SETPOINT_RST  = 16'h0190;
   localparam logic [15:0] FULLSCALE_RST = 16'h03e8;
   localparam logic [1:0]  MODE_OFF      = 2'h0;
   localparam logic [1:0]  MODE_WARN     = 2'h1;
   localparam logic [1:0]  MODE_STOP     = 2'h2;
   localparam logic [31:0] UNMAPPED_RD   = 32'h0000_0000;
   // status bit positions
   localparam int unsigned ST_SLEEP = 0;
   localparam int unsigned ST_HIW   = 1;
   localparam int unsigned ST_HIE   = 2;
   localparam int unsigned ST_LOW   = 3;
   localparam int unsigned ST_LOE   = 4;
   localparam int unsigned ST_LSW   = 5;
   localparam int unsigned ST_LSE   = 6;
   localparam int unsigned ST_PRB   = 7;
   // loop states
   typedef enum logic [3:0] {
      RUN_S      = 4'b0001,
      SLEEPCNT_S = 4'b0010,
      DECEL_S    = 4'b0100,
      SLEEP_S    = 4'b1000
   } loop_state_t;
endpackage

//--- pump_pressure_supervisor_asserts.sv
// checker for the pump pressure supervisor ports
// assumes one clock domain and one wait state per bus access
`timescale 1ns/1ps
`default_nettype none
module pump_pressure_supervisor_asserts (
   // clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [5:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o,
   // process side
   input wire logic        freq_down_o,
   input wire logic        freq_up_o,
   input wire logic        normal_decel_o,
   input wire logic        sleep_o,
   input wire logic        probe_active_o,
   input wire logic        probe_down_o,
   input wire logic        high_pressure_warning_o,
   input wire logic        high_pressure_stop_error_o,
   input wire logic        low_pressure_warning_o,
   input wire logic        low_pressure_stop_error_o,
   input wire logic        feedback_loss_fault_o,
   input wire logic        loss_warning_o,
   input wire logic        drive_stop_o
);
   // ==========================================================
   // clocking and bus sequences
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // one wait state, then the answer
   sequence s_one_wait;
      waitrequest_o ##1 !waitrequest_o;
   endsequence
   a_bus_answer_timing: assert property ($rose(read_i || write_i) |-> s_one_wait)
      else $error("bus answer not after one wait state");
   a_wait_one_cycle: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   a_answer_needs_req: assert property (!waitrequest_o |-> $past(read_i || write_i))
      else $error("answer without a request");
   a_unmapped_reads_zero: assert property
      (read_i && !waitrequest_o && address_i > 6'h38 |-> readdata_o == 32'h0)
      else $error("unmapped read not zero");
   // ==========================================================
   // supervision relations
   a_up_down_excl: assert property (!(freq_up_o && freq_down_o))
      else $error("frequency raised and lowered together");
   a_sleep_no_down: assert property (sleep_o |-> !freq_down_o)
      else $error("ramp down while asleep");
   a_decel_not_sleep: assert property (normal_decel_o |-> !sleep_o)
      else $error("decelerating while asleep");
   a_hi_err_order: assert property
      ($rose(high_pressure_stop_error_o) |-> high_pressure_warning_o)
      else $error("high stop error without warning");
   a_hi_err_stops: assert property
      ($rose(high_pressure_stop_error_o) |-> ##[0:2] drive_stop_o)
      else $error("high stop error did not stop drive");
   a_lo_err_order: assert property
      ($rose(low_pressure_stop_error_o) |-> low_pressure_warning_o)
      else $error("low stop error without warning");
   a_loss_kind_excl: assert property
      (!(feedback_loss_fault_o && loss_warning_o))
      else $error("loss reported as warning and error");
   a_probe_dir_down: assert property (probe_down_o |-> probe_active_o)
      else $error("downward probe without probe");
endmodule
bind pump_pressure_supervisor pump_pressure_supervisor_asserts
   pump_pressure_supervisor_asserts_inst (.clk_i, .rst_n_i, .address_i,
   .read_i, .write_i, .readdata_o, .waitrequest_o, .freq_down_o, .freq_up_o,
   .normal_decel_o, .sleep_o, .probe_active_o, .probe_down_o,
   .high_pressure_warning_o, .high_pressure_stop_error_o,
   .low_pressure_warning_o, .low_pressure_stop_error_o,
   .feedback_loss_fault_o, .loss_warning_o, .drive_stop_o);
`default_nettype wire

//--- pump_process_model.sv
// model of pressure transmitter and drive frequency path
// assumes the bench sets the line pressure directly
`timescale 1ns/1ps
`default_nettype none
module pump_process_model #(
   parameter logic [15:0] FREQ_MAX = 16'he9fc  // 599.00 hz top
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // line pressure and drive commands
   input  wire logic [15:0] pressure_i,
   input  wire logic        freq_down_i,
   input  wire logic        freq_up_i,
   input  wire logic        normal_decel_i,
   // measured values
   output var  logic [15:0] feedback_o,
   output var  logic [15:0] out_freq_o
);
   // ==========================================================
   // one step per cycle; real ramps are far slower
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         feedback_o <= 16'h0000;
         out_freq_o <= 16'h1770;
      end else begin
         feedback_o <= pressure_i;
         if ((freq_down_i || normal_decel_i) && out_freq_o != 16'h0) begin
            out_freq_o <= out_freq_o - 16'h1;
         end else if (freq_up_i && out_freq_o < FREQ_MAX) begin
            out_freq_o <= out_freq_o + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- pump_pressure_supervisor_tb.sv
// bench for the pump pressure supervisor register side
// assumes a shortened tick so the timers run out within the run
`timescale 1ns/1ps
`default_nettype none
module pump_pressure_supervisor_tb;
   import pump_supervisor_pkg::*;
   // ==========================================================
   // signals
   logic        clk_i, rst_n_i, read_i, write_i, waitrequest_o;
   logic [5:0]  address_i;
   logic [31:0] writedata_i, readdata_o, rd;
   logic [15:0] feedback_i, out_freq_i, pressure;
   logic        freq_down_o, freq_up_o, normal_decel_o, sleep_o;
   logic        probe_active_o, probe_down_o, drive_stop_o;
   logic        high_pressure_warning_o, high_pressure_stop_error_o;
   logic        low_pressure_warning_o, low_pressure_stop_error_o;
   logic        feedback_loss_fault_o, loss_warning_o;
   logic [12:0] outs;            // all process outputs
   int          mismatches, compares;
   localparam int unsigned TICK = 20;  // clocks per supervision tick
   assign outs = {freq_down_o, freq_up_o, normal_decel_o, sleep_o,
      probe_active_o, probe_down_o, high_pressure_warning_o,
      high_pressure_stop_error_o, low_pressure_warning_o,
      low_pressure_stop_error_o, feedback_loss_fault_o, loss_warning_o,
      drive_stop_o};
   // ==========================================================
   // design and far side
   pump_pressure_supervisor #(.TICK_LEN(TICK))
      pump_pressure_supervisor_inst (.clk_i, .rst_n_i,
      .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
      .waitrequest_o, .feedback_i, .out_freq_i, .freq_down_o, .freq_up_o,
      .normal_decel_o, .sleep_o, .probe_active_o, .probe_down_o,
      .high_pressure_warning_o, .high_pressure_stop_error_o,
      .low_pressure_warning_o, .low_pressure_stop_error_o,
      .feedback_loss_fault_o, .loss_warning_o, .drive_stop_o);
   pump_process_model pump_process_model_inst (.clk_i, .rst_n_i,
      .pressure_i(pressure), .freq_down_i(freq_down_o),
      .freq_up_i(freq_up_o), .normal_decel_i(normal_decel_o),
      .feedback_o(feedback_i), .out_freq_o(out_freq_i));
   // ==========================================================
   // clock and watchdog; the run needs a few hundred cycles
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      repeat (4000) @(posedge clk_i);
      mismatches++;
      final_report();
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus access; held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] a,
                         input logic [31:0] d);
      address_i   <= a;
      writedata_i <= d;
      read_i      <= !wr;
      write_i     <= wr;
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      rd = readdata_o;
      read_i  <= 1'b0;
      write_i <= 1'b0;
      @(posedge clk_i);  // gap so the next request starts cleanly
   endtask
   task automatic final_report();
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // settings written then read back; all within legal ranges
   logic [5:0]  wa [12] = '{OFS_TOLERANCE, OFS_MAXLIM, OFS_MINLIM,
      OFS_SLEEPFRQ, OFS_SLEEPTIM, OFS_HITIMES, OFS_LOTIMES, OFS_LOSS,
      OFS_MODES, OFS_PROBE, OFS_RAMP2, OFS_PID};
   logic [31:0] wd [12] = '{32'h00c8, 32'h0320, 32'h0064, 32'h0bb8,
      32'h0032, 32'h0064_0032, 32'h0064_0032, 32'h01f4_0064,
      32'h0000_0126, 32'h8064_0064, 32'h0064_0032, 32'h0064_0032};
   // ==========================================================
   // main sequence
   initial begin
      rst_n_i = 1'b0;
      {read_i, write_i, address_i, writedata_i} = '0;
      pressure = 16'h0190;
      mismatches = 0;
      compares = 0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      check({19'h0, outs}, 32'h0);
      check({31'h0, waitrequest_o}, 32'h1);
      access(1'b0, OFS_SETPOINT, 32'h0);
      check(rd, {16'h0, SETPOINT_RST});
      access(1'b0, OFS_FULLSCALE, 32'h0);
      check(rd, {16'h0, FULLSCALE_RST});
      // all twelve writes first, then every value read back
      for (int i = 0; i < 12; i++) access(1'b1, wa[i], wd[i]);
      for (int i = 0; i < 12; i++) begin
         access(1'b0, wa[i], 32'h0);
         check(rd, wd[i]);
      end
      // unmapped place ignores writes and reads zero
      access(1'b1, 6'h3c, 32'hffff_ffff);
      access(1'b0, 6'h3c, 32'h0);
      check(rd, UNMAPPED_RD);
      access(1'b0, OFS_SETPOINT, 32'h0);
      check(rd, {16'h0, SETPOINT_RST});
      // status clean: low warning still counting, nothing else due
      access(1'b0, OFS_STATUS, 32'h0);
      check(rd, 32'h0);
      // high side in pressure units: warn after 3 ticks, stop 2 later
      access(1'b1, OFS_HITIMES, 32'h0002_0003);
      access(1'b1, OFS_MODES, {30'h0, MODE_STOP});
      pressure <= 16'h0384;  // above the 800 limit and the setpoint
      repeat (2 * TICK) @(posedge clk_i);
      check({19'h0, outs}, 32'h1000);
      repeat (10 * TICK) @(posedge clk_i);
      check({19'h0, outs}, 32'h1061);
      pressure <= 16'h0190;  // back below limit, equal to the setpoint
      repeat (4 * TICK) @(posedge clk_i);
      check({31'h0, freq_down_o}, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
